// [hdlc_tx_pkg.sv]
`default_nettype none
package hdlc_tx_pkg;
    // Register addresses on the plain port
    localparam logic [3:0] ADDR_CMD = 4'h0;
    localparam logic [3:0] ADDR_DATA = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_MODE = 4'h4;
    localparam logic [3:0] ADDR_TXCTL = 4'h5;
    localparam logic [3:0] ADDR_ADDRM = 4'h6;
    localparam logic [3:0] ADDR_FLAG = 4'h7;
    localparam logic [3:0] ADDR_ENH = 4'h9;
    localparam logic [3:0] ADDR_LINK = 4'hA;
    // Field positions
    localparam int MODE_PAR_EN = 0;
    localparam int MODE_PAR_EVEN = 1;
    localparam int TXC_CRC_EN = 0;
    localparam int TXC_POLY = 2;
    localparam int TXC_TX_EN = 3;
    localparam int TXC_BITS_LO = 5;
    localparam int LINK_ABORT_UR = 2;
    localparam int LINK_MARK_IDLE = 3;
    localparam int LINK_PRESET = 7;
    localparam int ENH_AUTO_EOM = 1;
    localparam int ENH_REQ_ALL = 5;
    localparam int ST_IN_FRAME = 1;
    localparam int ST_ENTRY_EMPTY = 2;
    localparam int ST_EOM = 6;
    // Command codes
    localparam logic [1:0] CMD_RST_CRC = 2'h1;
    localparam logic [1:0] CMD_RST_EOM = 2'h3;
    localparam logic [2:0] CMD_ABORT = 3'h1;
    // Reset values
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] TXCTL_RST = 8'h00;
    localparam logic [7:0] LINK_RST = 8'h00;
    localparam logic [7:0] FLAG_RST = 8'h7E;
    localparam logic [7:0] ENH_RST = 8'h20;
    localparam logic [7:0] ADDRM_RST = 8'h00;
    // CRC polynomials, bit-reversed for lsb-first shifting
    localparam logic [15:0] POLY_CCITT = 16'h8408;
    localparam logic [15:0] POLY_CRC16 = 16'hA001;
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int BIT_TIME_NS = 1000;
    localparam int BIT_DIV = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ZERO_DELAY_BITS = 5;
    localparam logic [4:0] GROUP_BITS = 5'h08;
    localparam logic [4:0] CRC_BITS = 5'h10;
    localparam logic [2:0] STUFF_RUN = 3'h5;
    localparam logic [2:0] FIFO_DEPTH = 3'h4;
    // Kind of pattern in the shift register
    typedef enum logic [2:0] {
        K_MARK = 3'b000,
        K_FLAG = 3'b001,
        K_DATA = 3'b010,
        K_CRC = 3'b011,
        K_ABORT = 3'b100
    } kind_type;
    // One shift register load
    typedef struct packed {
        kind_type kind;
        logic [4:0] len;
        logic [15:0] data;
    } load_type;
endpackage : hdlc_tx_pkg
`default_nettype wire

// [hdlc_frame_transmitter.sv]
// Summary of operation
// - Zero after five ones, never in flags/aborts
// - Opening flag from pattern register before data
// - Mark idle ones go out eight at once
// - Five to eight bits, right justified
// - Optional parity bit, odd or even sense
// - Address fields are plain data, no matching
// - Entry-empty flag follows FIFO entry location
// - Request on entry empty or whole empty
// - Length sampled when character enters shifter
// - Polynomial select zero means CRC-CCITT
// - CRC preset to ones or zeros
// - CRC accumulates over frame characters
// - Auto mode resets CRC and latch per frame
// - Underrun sends flag, CRC or abort
// - Abort command: eight ones, FIFO cleared
// - Five bit times through zero inserter
// - Latch sets when CRC or abort loaded
// - Disable finishes character, CRC length kept
// - CRC sent inverted
`timescale 1ns/10ps
`default_nettype none
module hdlc_frame_transmitter
    import hdlc_tx_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic txd_o,
    output logic tx_req_o,
    output logic eom_evt_o
);
    localparam int DLY_CYC = ZERO_DELAY_BITS * BIT_DIV;

    // Software registers
    logic [7:0] mode_reg;
    logic [7:0] txctl_reg;
    logic [7:0] addrm_reg; // Receiver only, never read by transmit logic
    logic [7:0] flag_reg;
    logic [7:0] enh_reg;
    logic [7:0] link_reg;
    // FIFO
    logic [7:0] fifo_mem [4];
    logic [1:0] wr_ptr_reg;
    logic [1:0] rd_ptr_reg;
    logic [2:0] cnt_reg;
    // Transmit state
    load_type sh_reg;
    logic [2:0] ones_reg;
    logic [15:0] crc_reg;
    logic eom_reg;
    logic in_frame_reg;
    logic flag_due_reg;
    logic abort_pend_reg;
    logic [7:0] div_reg;
    logic [4:0] dly_reg;
    // Combinational
    logic tick;
    logic cmd_wr;
    logic crc_rst_cmd;
    logic eom_rst_cmd;
    logic abort_cmd;
    logic push;
    logic tx_en;
    logic ld_go;
    load_type ld;
    load_type src;
    logic pop;
    logic set_eom;
    logic start_frame;
    logic end_frame;
    logic ur_end;
    logic stuff;
    logic bit_out;
    logic [4:0] crc_idx;
    logic [4:0] nbits;
    logic [7:0] cmask;
    logic [7:0] chr;
    logic par;
    logic [15:0] crc_step;
    logic [15:0] preset;

    // Character length from the two length bits
    function automatic logic [4:0] char_len(input logic [1:0] code);
        case (code)
            2'h0: char_len = 5'h05;
            2'h1: char_len = 5'h07;
            2'h2: char_len = 5'h06;
            default: char_len = 5'h08;
        endcase
    endfunction : char_len

    // One lsb-first CRC step
    function automatic logic [15:0] crc_bit(input logic [15:0] c,
            input logic b, input logic [15:0] poly);
        crc_bit = {1'b0, c[15:1]} ^ ((c[0] ^ b) ? poly : 16'h0000);
    endfunction : crc_bit

    // Command decode, one pulse per write
    assign cmd_wr = wr_i && (addr_i == ADDR_CMD);
    assign crc_rst_cmd = cmd_wr && (wdata_i[7:6] == CMD_RST_CRC);
    assign eom_rst_cmd = cmd_wr && (wdata_i[7:6] == CMD_RST_EOM);
    assign abort_cmd = cmd_wr && (wdata_i[5:3] == CMD_ABORT);
    assign push = wr_i && (addr_i == ADDR_DATA) && (cnt_reg != FIFO_DEPTH);
    assign tx_en = txctl_reg[TXC_TX_EN];

    // Configuration writes
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            mode_reg <= MODE_RST;
            txctl_reg <= TXCTL_RST;
            addrm_reg <= ADDRM_RST;
            flag_reg <= FLAG_RST;
            enh_reg <= ENH_RST;
            link_reg <= LINK_RST;
        end else if (wr_i) begin
            if (addr_i == ADDR_MODE) begin
                mode_reg <= wdata_i;
            end else if (addr_i == ADDR_TXCTL) begin
                txctl_reg <= wdata_i;
            end else if (addr_i == ADDR_ADDRM) begin
                addrm_reg <= wdata_i;
            end else if (addr_i == ADDR_FLAG) begin
                flag_reg <= wdata_i;
            end else if (addr_i == ADDR_ENH) begin
                enh_reg <= wdata_i;
            end else if (addr_i == ADDR_LINK) begin
                link_reg <= wdata_i;
            end
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            if (addr_i == ADDR_STATUS) begin
                rdata_o <= 8'h00;
                rdata_o[ST_IN_FRAME] <= in_frame_reg;
                rdata_o[ST_ENTRY_EMPTY] <= (cnt_reg != FIFO_DEPTH);
                rdata_o[ST_EOM] <= eom_reg;
            end else if (addr_i == ADDR_MODE) begin
                rdata_o <= mode_reg;
            end else if (addr_i == ADDR_TXCTL) begin
                rdata_o <= txctl_reg;
            end else if (addr_i == ADDR_ADDRM) begin
                rdata_o <= addrm_reg;
            end else if (addr_i == ADDR_FLAG) begin
                rdata_o <= flag_reg;
            end else if (addr_i == ADDR_ENH) begin
                rdata_o <= enh_reg;
            end else if (addr_i == ADDR_LINK) begin
                rdata_o <= link_reg;
            end else begin
                rdata_o <= 8'h00;
            end
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // Bit rate divider
    always_ff @(posedge clk_i) begin
        if (!nrst_i || tick) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end
    assign tick = (div_reg == 8'(BIT_DIV - 1));

    // Request on entry empty or on whole FIFO empty
    assign tx_req_o = tx_en && (enh_reg[ENH_REQ_ALL] ? (cnt_reg == 3'h0)
                                : (cnt_reg != FIFO_DEPTH));

    // FIFO storage and pointers, abort clears it
    always_ff @(posedge clk_i) begin
        if (!nrst_i || abort_cmd) begin
            wr_ptr_reg <= 2'h0;
            rd_ptr_reg <= 2'h0;
            cnt_reg <= 3'h0;
        end else begin
            if (push) begin
                fifo_mem[wr_ptr_reg] <= wdata_i;
                wr_ptr_reg <= wr_ptr_reg + 2'h1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 2'h1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 3'h1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 3'h1;
            end
        end
    end

    // Character formatting: length taken at load time
    always_comb begin
        nbits = char_len(txctl_reg[TXC_BITS_LO+1:TXC_BITS_LO]);
        cmask = 8'hFF >> (4'h8 - nbits[3:0]);
        chr = fifo_mem[rd_ptr_reg] & cmask;
        par = (^chr) ^ ~mode_reg[MODE_PAR_EVEN];
    end

    // Next pattern choice when the shifter runs empty
    always_comb begin
        ld_go = tick && (sh_reg.len == 5'h00);
        ld = '{kind: K_MARK, len: GROUP_BITS, data: 16'hFFFF};
        pop = 1'b0;
        set_eom = 1'b0;
        start_frame = 1'b0;
        end_frame = 1'b0;
        ur_end = 1'b0;
        if (!ld_go) begin
            // Keep current pattern
        end else if (abort_pend_reg) begin
            ld.kind = K_ABORT;
            set_eom = 1'b1;
        end else if (flag_due_reg) begin
            ld = '{kind: K_FLAG, len: GROUP_BITS, data: {8'h00, flag_reg}};
        end else if (!tx_en) begin
            ld.kind = K_MARK;
        end else if (cnt_reg != 3'h0) begin
            if (!in_frame_reg) begin
                ld = '{kind: K_FLAG, len: GROUP_BITS, data: {8'h00, flag_reg}};
                start_frame = 1'b1;
            end else begin
                ld.kind = K_DATA;
                ld.len = nbits + {4'h0, mode_reg[MODE_PAR_EN]};
                ld.data = {8'h00, chr} | (mode_reg[MODE_PAR_EN] ?
                          (16'(par) << nbits) : 16'h0000);
                pop = 1'b1;
            end
        end else if (in_frame_reg) begin
            end_frame = 1'b1;
            if (eom_reg) begin
                ld = '{kind: K_FLAG, len: GROUP_BITS, data: {8'h00, flag_reg}};
            end else if (link_reg[LINK_ABORT_UR]) begin
                ld.kind = K_ABORT;
                set_eom = 1'b1;
                ur_end = 1'b1;
            end else begin
                ld = '{kind: K_CRC, len: CRC_BITS, data: ~crc_reg};
                set_eom = 1'b1;
                ur_end = 1'b1;
            end
        end else if (link_reg[LINK_MARK_IDLE]) begin
            ld.kind = K_MARK;
        end else begin
            ld = '{kind: K_FLAG, len: GROUP_BITS, data: {8'h00, flag_reg}};
        end
    end

    // Bit source, zero insertion and CRC step
    always_comb begin
        src = (sh_reg.len == 5'h00) ? ld : sh_reg;
        // Run count grows only in data and CRC, so a run of five is
        // broken even when a flag or mark follows; aborts stay pure ones
        stuff = (src.kind != K_ABORT) && (ones_reg == STUFF_RUN);
        crc_idx = CRC_BITS - src.len;
        bit_out = 1'b1;
        if (stuff) begin
            bit_out = 1'b0;
        end else if ((src.kind == K_CRC) && !tx_en) begin
            bit_out = flag_reg[crc_idx[2:0]];
        end else begin
            bit_out = src.data[0];
        end
        crc_step = crc_bit(crc_reg, src.data[0],
                   txctl_reg[TXC_POLY] ? POLY_CRC16 : POLY_CCITT);
        preset = link_reg[LINK_PRESET] ? 16'hFFFF : 16'h0000;
    end

    // Shift register, advanced once per bit time
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            sh_reg <= '{kind: K_MARK, len: 5'h00, data: 16'h0000};
            ones_reg <= 3'h0;
        end else if (tick) begin
            if (stuff) begin
                sh_reg <= src; // Inserted zero holds the bit
                ones_reg <= 3'h0;
            end else begin
                sh_reg.kind <= src.kind;
                sh_reg.len <= src.len - 5'h01;
                sh_reg.data <= {1'b0, src.data[15:1]};
                // Flags and aborts restart the run count
                if ((src.kind == K_DATA) || (src.kind == K_CRC)) begin
                    ones_reg <= bit_out ? ones_reg + 3'h1 : 3'h0;
                end else begin
                    ones_reg <= 3'h0;
                end
            end
        end
    end

    // CRC generator
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            crc_reg <= 16'hFFFF;
        end else if (crc_rst_cmd || (start_frame && enh_reg[ENH_AUTO_EOM])) begin
            crc_reg <= preset;
        end else if (tick && !stuff && (src.kind == K_DATA) &&
                     txctl_reg[TXC_CRC_EN]) begin
            crc_reg <= crc_step;
        end
    end

    // End-of-message latch, set wins over clear
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            eom_reg <= 1'b1;
        end else if (set_eom) begin
            eom_reg <= 1'b1;
        end else if (eom_rst_cmd || (start_frame && enh_reg[ENH_AUTO_EOM])) begin
            eom_reg <= 1'b0;
        end
    end
    logic eom_pulse_reg; // Latch set event, one cycle long
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            eom_pulse_reg <= 1'b0;
        end else begin
            eom_pulse_reg <= set_eom;
        end
    end
    assign eom_evt_o = eom_pulse_reg;

    // Frame state, pending abort and closing flag
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            in_frame_reg <= 1'b0;
            flag_due_reg <= 1'b0;
            abort_pend_reg <= 1'b0;
        end else begin
            if (abort_cmd) begin
                abort_pend_reg <= 1'b1;
                in_frame_reg <= 1'b0;
            end else if (ld_go && abort_pend_reg) begin
                abort_pend_reg <= 1'b0;
            end
            if (!abort_cmd && start_frame) begin
                in_frame_reg <= 1'b1;
            end else if (!abort_cmd && end_frame) begin
                in_frame_reg <= 1'b0;
            end
            if (ur_end) begin
                flag_due_reg <= 1'b1;
            end else if (ld_go && flag_due_reg && !abort_pend_reg) begin
                flag_due_reg <= 1'b0;
            end
        end
    end

    // Inserter delay line to the pin
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            dly_reg <= 5'h1F;
        end else if (tick) begin
            dly_reg <= {dly_reg[3:0], bit_out};
        end
    end
    assign txd_o = dly_reg[4];

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    chk_zero_insert: assert property (tick && stuff |-> !bit_out ##1 ones_reg == 3'h0)
        else $error("no zero after five ones");
    chk_open_flag: assert property (start_frame |-> ld.kind == K_FLAG && ld.data[7:0] == flag_reg)
        else $error("frame did not open with flag");
    chk_mark_group: assert property (
        ld_go && ld.kind == K_MARK
        |=> sh_reg.len == ($past(stuff) ? GROUP_BITS : GROUP_BITS - 5'h01))
        else $error("mark group not eight bits");
    chk_char_length: assert property (
        pop |=> sh_reg.len == $past(nbits)
            + {4'h0, $past(mode_reg[MODE_PAR_EN])}
            - {4'h0, !$past(stuff)})
        else $error("character length wrong");
    chk_parity_sense: assert property (pop && mode_reg[MODE_PAR_EN] |-> (^ld.data) == ~mode_reg[MODE_PAR_EVEN])
        else $error("parity sense wrong");
    chk_entry_flag: assert property (
        rd_i && addr_i == ADDR_STATUS && cnt_reg == FIFO_DEPTH
        |=> !rdata_o[ST_ENTRY_EMPTY])
        else $error("entry empty flag wrong");
    chk_request_all: assert property (enh_reg[ENH_REQ_ALL] && cnt_reg != 3'h0 |-> !tx_req_o)
        else $error("request with data left");
    chk_eom_set: assert property (
        ld_go && (ld.kind == K_CRC || ld.kind == K_ABORT)
        |=> eom_reg && eom_evt_o)
        else $error("latch not set on crc or abort");
    chk_underrun_flag: assert property (end_frame && eom_reg |-> ld.kind == K_FLAG ##1 !in_frame_reg)
        else $error("underrun with latch did not send flag");
    chk_crc_invert: assert property (ld_go && ld.kind == K_CRC |-> ld.data == ~crc_reg)
        else $error("crc not inverted");
    chk_abort_clear: assert property (abort_cmd |=> cnt_reg == 3'h0 && abort_pend_reg)
        else $error("abort did not clear fifo");
    chk_pin_delay: assert property (tick |-> ##DLY_CYC txd_o == $past(bit_out, DLY_CYC))
        else $error("inserter delay wrong");
    chk_crc_disable: assert property (tick && !stuff && src.kind == K_CRC && !tx_en |-> bit_out == flag_reg[crc_idx[2:0]])
        else $error("disabled crc not from flag");

    cov_crc_end: cover property (ld_go && ld.kind == K_CRC ##[1:400] ld_go && ld.kind == K_FLAG);
    cov_abort_cmd: cover property (abort_cmd ##[1:400] ld_go && ld.kind == K_ABORT);
    cov_underrun_abort: cover property (end_frame && ld.kind == K_ABORT);
endmodule : hdlc_frame_transmitter
`default_nettype wire

// [dummy_unused_marker.sv]
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [frame_receiver.sv]
`timescale 1ns/10ps
`default_nettype none
// Remote station: samples mid-bit, hunts flags, strips stuffed zeros
module frame_receiver (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic line_i,
    output int frames_o,
    output int aborts_o,
    output logic [63:0] bits_o,
    output int nbits_o
);
    logic [3:0] div_reg; // Bit time divider
    logic [7:0] win_reg; // Last eight line bits
    logic [63:0] acc_reg; // Bits since last flag
    int cnt_reg; // Count of kept bits
    int ones_reg; // Current run of ones
    logic open_reg; // Between flags
    logic [7:0] win; // Window with the new bit
    assign win = {line_i, win_reg[7:1]};
    // Sample each bit in its middle
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            div_reg <= 4'h0;
            win_reg <= 8'h00;
            ones_reg <= 0;
            open_reg <= 1'b0;
            cnt_reg <= 0;
            acc_reg <= 64'h0;
            frames_o <= 0;
            aborts_o <= 0;
            bits_o <= 64'h0;
            nbits_o <= 0;
        end else begin
            div_reg <= (div_reg == 4'h9) ? 4'h0 : div_reg + 4'h1;
            if (div_reg == 4'h5) begin
                win_reg <= win;
                ones_reg <= line_i ? ones_reg + 1 : 0;
                if (line_i && ones_reg >= 6) begin
                    // Seventh one in a row ends the frame as aborted
                    aborts_o <= open_reg ? aborts_o + 1 : aborts_o;
                    open_reg <= 1'b0;
                end else if (win == 8'h7E) begin
                    // Flag closes one frame and opens the next
                    if (open_reg && cnt_reg > 7) begin
                        frames_o <= frames_o + 1;
                        bits_o <= acc_reg & ((64'h1 << (cnt_reg - 7)) - 64'h1);
                        nbits_o <= cnt_reg - 7;
                    end
                    open_reg <= 1'b1;
                    cnt_reg <= 0;
                end else if (open_reg && cnt_reg < 64 &&
                             !(!line_i && ones_reg == 5)) begin
                    // Keep the bit unless it is a stuffed zero
                    acc_reg[cnt_reg] <= line_i;
                    cnt_reg <= cnt_reg + 1;
                end
            end
        end
    end
endmodule : frame_receiver
`default_nettype wire

// [testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench
    import hdlc_tx_pkg::*;
;
    logic clk_i = 1'b0; // Bench clock
    logic nrst_i; // Reset, active low
    logic [3:0] addr_i; // Register address
    logic [7:0] wdata_i; // Write data
    logic wr_i; // Write strobe
    logic rd_i; // Read strobe
    logic [7:0] rdata_o; // Read data
    logic txd_o; // Serial line
    logic tx_req_o; // Transmit request
    logic eom_evt_o; // Latch set event
    int frames; // Frames seen remotely
    int aborts; // Aborts seen remotely
    logic [63:0] rx_bits; // Last frame content
    int rx_nbits; // Last frame length
    int num_errors = 0; // Mismatch count
    int checks_done = 0; // Comparison count
    int eom_cnt = 0; // Latch set events
    int f0; // Frame count snapshot
    int a0; // Abort count snapshot
    int e0; // Event count snapshot
    logic [7:0] s; // Read value
    int zeros = 0; // Zero bits seen while idling mark
    typedef struct {
        logic [7:0] ctl;
        logic [7:0] mode;
        logic [7:0] data;
        logic [8:0] bits;
        int n;
    } row_type;
    // Length and parity cases, no CRC
    row_type rows [6] = '{
        '{8'h68, 8'h00, 8'hA5, 9'h0A5, 8},
        '{8'h08, 8'h00, 8'hFF, 9'h01F, 5},
        '{8'h28, 8'h00, 8'h81, 9'h001, 7},
        '{8'h48, 8'h00, 8'hC3, 9'h003, 6},
        '{8'h68, 8'h03, 8'h03, 9'h003, 9},
        '{8'h68, 8'h01, 8'h03, 9'h103, 9}};

    always #50 clk_i = ~clk_i;

    hdlc_frame_transmitter dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .txd_o(txd_o), .tx_req_o(tx_req_o),
        .eom_evt_o(eom_evt_o));

    frame_receiver rx_u (.clk_i(clk_i), .nrst_i(nrst_i), .line_i(txd_o),
        .frames_o(frames), .aborts_o(aborts), .bits_o(rx_bits),
        .nbits_o(rx_nbits));

    // Count latch set events
    always @(posedge clk_i) begin
        if (eom_evt_o === 1'b1) begin
            eom_cnt <= eom_cnt + 1;
        end
    end

    task check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // One-cycle register write
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    // One-cycle read, data taken in the following cycle
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd

    // Wait for the next frame or abort at the far end
    task wait_rx(input bit ab, input int c0);
        for (int i = 0; i < 3000 && (ab ? aborts : frames) == c0; i++) begin
            @(posedge clk_i);
        end
        check(64'(ab ? aborts : frames), 64'(c0 + 1));
    endtask : wait_rx

    // Inverted CRC-CCITT over n bits, lsb first
    function automatic logic [15:0] crc_of(input logic [23:0] d, input int n,
                                           input logic [15:0] c);
        for (int i = 0; i < n; i++) begin
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ POLY_CCITT) : (c >> 1);
        end
        return ~c;
    endfunction : crc_of

    // Compare a received frame with data followed by CRC
    task crc_check(input logic [23:0] d, input int n, input logic [15:0] pre);
        check(64'(rx_nbits), 64'(n + 16));
        check(rx_bits, (64'(crc_of(d, n, pre)) << n) | 64'(d));
    endtask : crc_check

    task results;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    // Watchdog against a hung run
    initial begin
        repeat (30000) @(posedge clk_i);
        num_errors++;
        results();
    end

    initial begin
        nrst_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd(ADDR_STATUS, s);
        check(s, 8'h44);
        rd(4'h3, s);
        check(s, 8'h00);
        check(txd_o, 1'b1);
        check(tx_req_o, 1'b0);
        // Set-up order: mode, link, flag, address match, enable, CRC reset
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_LINK, 8'h80);
        wr(ADDR_FLAG, 8'h7E);
        wr(ADDR_ADDRM, 8'hA5);
        wr(ADDR_TXCTL, 8'h68);
        wr(ADDR_CMD, 8'h40);
        // Latch still set: each frame closes with a flag only
        foreach (rows[i]) begin
            f0 = frames;
            wr(ADDR_MODE, rows[i].mode);
            wr(ADDR_TXCTL, rows[i].ctl);
            wr(ADDR_DATA, rows[i].data);
            wait_rx(1'b0, f0);
            check(64'(rx_nbits), 64'(rows[i].n));
            check(rx_bits, 64'(rows[i].bits));
        end
        // Manual CRC frame, preset to ones
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_TXCTL, 8'h69);
        wr(ADDR_CMD, 8'h40);
        f0 = frames;
        e0 = eom_cnt;
        wr(ADDR_DATA, 8'h5A);
        wr(ADDR_CMD, 8'hC0);
        wait_rx(1'b0, f0);
        crc_check(24'h00005A, 8, 16'hFFFF);
        check(64'(eom_cnt), 64'(e0 + 1));
        // Automatic latch and CRC reset, preset to zeros
        wr(ADDR_LINK, 8'h00);
        wr(ADDR_ENH, 8'h22);
        f0 = frames;
        wr(ADDR_DATA, 8'h81);
        wr(ADDR_DATA, 8'h3C);
        wr(ADDR_DATA, 8'hC3);
        rd(ADDR_STATUS, s);
        check(s[ST_ENTRY_EMPTY], 1'b1);
        check(tx_req_o, 1'b0);
        wr(ADDR_ENH, 8'h02);
        #1 check(tx_req_o, 1'b1);
        wr(ADDR_ENH, 8'h22);
        wait_rx(1'b0, f0);
        crc_check(24'hC33C81, 24, 16'h0000);
        // Underrun with abort selected
        wr(ADDR_ENH, 8'h20);
        wr(ADDR_LINK, 8'h84);
        a0 = aborts;
        e0 = eom_cnt;
        wr(ADDR_DATA, 8'h55);
        wr(ADDR_CMD, 8'hC0);
        wait_rx(1'b1, a0);
        check(64'(eom_cnt), 64'(e0 + 1));
        // Abort command in mid-frame drops the queued bytes
        wr(ADDR_LINK, 8'h80);
        f0 = frames;
        a0 = aborts;
        wr(ADDR_DATA, 8'h11);
        wr(ADDR_DATA, 8'h22);
        wr(ADDR_DATA, 8'h33);
        wr(ADDR_DATA, 8'h44);
        rd(ADDR_STATUS, s);
        check(s[ST_ENTRY_EMPTY], 1'b0);
        wr(ADDR_CMD, 8'hC0);
        repeat (100) @(posedge clk_i);
        wr(ADDR_CMD, 8'h08);
        wait_rx(1'b1, a0);
        rd(ADDR_STATUS, s);
        check(s & 8'h44, 8'h44);
        repeat (600) @(posedge clk_i);
        check(64'(frames), 64'(f0));
        // Mark idle sends only ones, then back to flags before data
        wr(ADDR_LINK, 8'h88);
        repeat (150) @(posedge clk_i);
        for (int i = 0; i < 200; i++) begin
            @(posedge clk_i);
            zeros += (txd_o !== 1'b1);
        end
        check(64'(zeros), 64'h0);
        wr(ADDR_LINK, 8'h80);
        repeat (80) @(posedge clk_i);
        f0 = frames;
        wr(ADDR_DATA, 8'h3C);
        wait_rx(1'b0, f0);
        check(64'(rx_nbits), 64'h8);
        check(rx_bits, 64'h3C);
        // Reset in mid-run brings back the power-up state
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd(ADDR_STATUS, s);
        check(s, 8'h44);
        check(tx_req_o, 1'b0);
        check(txd_o, 1'b1);
        results();
    end
endmodule : testbench
`default_nettype wire
